// ==== dptc_top.sv ====
// What this block does
// - Table base register holds the first-level table address in bits 55:12.
// - Base aligned to larger of 4KB and table size; low unused bits act as zero but read back as written.
// - Base bits above output address size read and act as zero.
// - Base and config are read-only while walk enable or its acknowledge is set.
// - Level-0 span field bits 23:20 encodes 30, 34, 36 or 39 bits.
// - Granule field bits 15:14: 4KB, 64KB, 16KB; invalid when unsupported.
// - Region size field bits 2:0 encodes 32 to 52 bits; 0b111 reserved.
// - Span, granule and region size may be cached, so changes may lag.
// - Syndrome bits 55:12 hold the faulting address; zero while flag clear.
// - Fault code bits 7:4: disabled, invalid, protection fault, abort.
// - Syndrome bit 1 gives the faulting level; zero with no fault.
// - Syndrome bit 0 is a sticky fault flag, reset to zero.
// - Writing one to the fault flag does nothing at all.
// - Writes not clearing the flag are ignored; a clearing write zeroes all.
// - Syndrome describes the fault shown by the global error table bit.
// - No-access results are not faults and leave the syndrome alone.
//
// The implementer's own choice: the plain strobed port.
module dptc_top #(
   parameter int OA_BITS   = 48,
   parameter bit GRANULE_4K_SUPPORTED_OK = 1'b1,
   parameter bit GRAN16K_OK = 1'b1,
   parameter bit GRAN64K_OK = 1'b1
) (
   // Clock and reset
   input  wire logic                        clk_in,
   input  wire logic                        reset_in,
   // Register port
   input  wire logic [11:0]                 addr_in,
   input  wire logic [31:0]                 wdata_in,
   input  wire logic                        wr_in,
   input  wire logic                        rd_in,
   output logic      [31:0]                 rdata_out,
   // Lookup fault report from the table walker
   input  wire logic                        fault_valid_in,
   input  wire logic [dptc_pkg::ADDR_W-1:0] fault_addr_in,
   input  wire logic [3:0]                  fault_code_in,
   input  wire logic                        fault_level_in,
   input  wire logic                        fault_no_access_in,
   // Configuration toward the walker
   output logic      [dptc_pkg::ADDR_W-1:0] table_base_address_out,
   output logic                             read_allocate_hint_out,
   output logic      [3:0]                  level0_span_out,
   output logic      [1:0]                  table_granule_out,
   output logic      [2:0]                  protected_region_size_out,
   output logic                             config_valid_out,
   output logic                             walk_enable_out,
   output logic                             control_acknowledge_out,
   output logic                             permission_table_error_out
);

   typedef struct packed {
      logic [dptc_pkg::ADDR_W-1:0] base;
      logic                        ra;
      logic [3:0]                  span;
      logic [1:0]                  gran;
      logic [2:0]                  ps;
      logic                        walk_en;
      logic                        walk_ack;
      logic                        gerr;
      logic                        gerr_ack;
      logic                        err;
      logic [31:0]                 rdata;
      logic [dptc_pkg::ADDR_W-1:0] base_eff;
      logic                        cfg_ok;
   } dptc_st_s;

   dptc_st_s             st_r;
   dptc_st_s             st_nxt;
   dptc_pkg::dptc_synd_s synd;
   dptc_fault_if         flt ();
   logic [63:0]          base_word;
   logic [63:0]          synd_word;
   logic [dptc_pkg::ADDR_W-1:0] oa_mask;
   logic [dptc_pkg::ADDR_W-1:0] align_mask;
   logic                 locked;
   logic                 span_ok;
   logic                 gran_ok;
   logic                 ps_ok;
   logic [5:0]           span_bits;
   logic [5:0]           ps_bits;

   // ===============================================================
   // Syndrome store
   assign flt.valid     = fault_valid_in;
   assign flt.addr      = fault_addr_in;
   assign flt.code      = fault_code_in;
   assign flt.level     = fault_level_in;
   assign flt.no_access = fault_no_access_in;
   // Only a write of zero to the flag bit clears; a one changes nothing.
   assign flt.clear     = wr_in && (addr_in == dptc_pkg::SYND_LO_OFS)
                          && !wdata_in[dptc_pkg::FAULT_BIT] && synd.fault;

   dptc_syndrome #(
      .OA_BITS (OA_BITS)
   ) u_synd (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .flt      (flt),
      .synd_out (synd)
   );

   // ===============================================================
   // Field decode and checks
   always_comb begin
      span_ok   = 1'b1;
      span_bits = 6'h1E;
      case (st_r.span)
         dptc_pkg::SPAN_30: span_bits = 6'h1E;
         dptc_pkg::SPAN_34: span_bits = 6'h22;
         dptc_pkg::SPAN_36: span_bits = 6'h24;
         dptc_pkg::SPAN_39: span_bits = 6'h27;
         default: span_ok = 1'b0;
      endcase
      ps_ok   = 1'b1;
      ps_bits = 6'h20;
      case (st_r.ps)
         3'h0: ps_bits = 6'h20;
         3'h1: ps_bits = 6'h24;
         3'h2: ps_bits = 6'h28;
         3'h3: ps_bits = 6'h2A;
         3'h4: ps_bits = 6'h2C;
         3'h5: ps_bits = 6'h30;
         3'h6: ps_bits = 6'h34;
         default: ps_ok = 1'b0;
      endcase
      case (st_r.gran)
         dptc_pkg::GRAN_4K:  gran_ok = GRANULE_4K_SUPPORTED_OK;
         dptc_pkg::GRAN_64K: gran_ok = GRAN64K_OK;
         dptc_pkg::GRAN_16K: gran_ok = GRAN16K_OK;
         default:            gran_ok = 1'b0;
      endcase
   end

   // ===============================================================
   // Address masks. The level-0 table holds 2^(ps-span) entries of 8 bytes,
   // so alignment clears bits below ps-span+3, never fewer than 12.
   always_comb begin
      oa_mask    = '0;
      align_mask = '0;
      for (int i = 0; i < dptc_pkg::ADDR_W; i++) begin
         if (i + dptc_pkg::ADDR_LSB < OA_BITS) begin
            oa_mask[i] = 1'b1;
         end
         if (i + dptc_pkg::ADDR_LSB >= int'(ps_bits) - int'(span_bits) + 3) begin
            align_mask[i] = 1'b1;
         end
      end
   end

   assign locked    = st_r.walk_en || st_r.walk_ack;
   assign base_word = {1'b0, st_r.ra, 6'h00, st_r.base & oa_mask, 12'h000};
   assign synd_word = {8'h00, synd.addr, 4'h0, synd.code, 2'b00, synd.level,
                       synd.fault};

   // ===============================================================
   // Register file and derived state
   always_comb begin
      st_nxt       = st_r;
      st_nxt.rdata = dptc_pkg::ZERO_WORD;
      if (wr_in) begin
         case (addr_in)
            dptc_pkg::BASE_LO_OFS: begin
               if (!locked) begin
                  st_nxt.base[19:0] = wdata_in[31:12];
               end
            end
            dptc_pkg::BASE_HI_OFS: begin
               if (!locked) begin
                  st_nxt.base[dptc_pkg::ADDR_W-1:20] = wdata_in[23:0];
                  st_nxt.ra = wdata_in[dptc_pkg::RA_BIT-32];
               end
            end
            dptc_pkg::CFG_OFS: begin
               if (!locked) begin
                  st_nxt.span = wdata_in[dptc_pkg::SPAN_LSB+:4];
                  st_nxt.gran = wdata_in[dptc_pkg::GRAN_LSB+:2];
                  st_nxt.ps   = wdata_in[dptc_pkg::PS_LSB+:3];
               end
            end
            dptc_pkg::CTRL_OFS: begin
               st_nxt.walk_en = wdata_in[0];
            end
            dptc_pkg::GERR_OFS: begin
               st_nxt.gerr_ack = wdata_in[1];
            end
            default: begin
            end
         endcase
      end
      // Acknowledge follows enable one cycle later, so the lock spans the handover.
      st_nxt.walk_ack = st_r.walk_en;
      // Error toggles like an acknowledged global error bit; set wins over ack.
      if (flt.load) begin
         st_nxt.gerr = ~st_nxt.gerr_ack;
      end
      // Registered so the error pin comes straight from a flop, with no added lag.
      st_nxt.err = st_nxt.gerr ^ st_nxt.gerr_ack;
      if (rd_in) begin
         case (addr_in)
            dptc_pkg::BASE_LO_OFS: st_nxt.rdata = base_word[31:0];
            dptc_pkg::BASE_HI_OFS: st_nxt.rdata = base_word[63:32];
            dptc_pkg::CFG_OFS:     st_nxt.rdata = {8'h00, st_r.span, 4'h0, st_r.gran,
                                                   11'h000, st_r.ps};
            dptc_pkg::SYND_LO_OFS: st_nxt.rdata = synd_word[31:0];
            dptc_pkg::SYND_HI_OFS: st_nxt.rdata = synd_word[63:32];
            dptc_pkg::CTRL_OFS:    st_nxt.rdata = {30'h0000_0000, st_r.walk_ack,
                                                   st_r.walk_en};
            dptc_pkg::GERR_OFS:    st_nxt.rdata = {30'h0000_0000, st_r.gerr_ack,
                                                   st_r.gerr};
            default:               st_nxt.rdata = dptc_pkg::ZERO_WORD;
         endcase
      end
      // Walker sees base and config valid after one more register stage, which models the cached copy.
      st_nxt.base_eff = st_r.base & oa_mask & align_mask;
      st_nxt.cfg_ok   = span_ok && ps_ok && gran_ok && (ps_bits <= 6'(OA_BITS))
                        && (span_bits <= ps_bits);
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata_out                  = st_r.rdata;
   assign table_base_address_out     = st_r.base_eff;
   assign read_allocate_hint_out     = st_r.ra;
   assign level0_span_out            = st_r.span;
   assign table_granule_out          = st_r.gran;
   assign protected_region_size_out  = st_r.ps;
   assign config_valid_out           = st_r.cfg_ok;
   assign walk_enable_out            = st_r.walk_en;
   assign control_acknowledge_out    = st_r.walk_ack;
   assign permission_table_error_out = st_r.err;

endmodule

// ==== dptc_pkg.sv ====
package dptc_pkg;

   // ===============================================================
   // Register map
   localparam logic [11:0] BASE_LO_OFS   = 12'h200;
   localparam logic [11:0] BASE_HI_OFS   = 12'h204;
   localparam logic [11:0] CFG_OFS       = 12'h208;
   localparam logic [11:0] SYND_LO_OFS   = 12'h210;
   localparam logic [11:0] SYND_HI_OFS   = 12'h214;
   localparam logic [11:0] CTRL_OFS      = 12'h220;
   localparam logic [11:0] GERR_OFS      = 12'h224;

   // ===============================================================
   // Field positions
   localparam int ADDR_LSB      = 12;
   localparam int ADDR_MSB      = 55;
   localparam int RA_BIT        = 62;
   localparam int SPAN_LSB      = 20;
   localparam int GRAN_LSB      = 14;
   localparam int PS_LSB        = 0;
   localparam int CODE_LSB      = 4;
   localparam int LEVEL_BIT     = 1;
   localparam int FAULT_BIT     = 0;
   localparam int ADDR_W        = ADDR_MSB - ADDR_LSB + 1;

   // ===============================================================
   // Encodings
   localparam logic [3:0] SPAN_30 = 4'h0;
   localparam logic [3:0] SPAN_34 = 4'h4;
   localparam logic [3:0] SPAN_36 = 4'h6;
   localparam logic [3:0] SPAN_39 = 4'h9;
   localparam logic [1:0] GRAN_4K  = 2'h0;
   localparam logic [1:0] GRAN_64K = 2'h1;
   localparam logic [1:0] GRAN_16K = 2'h2;
   localparam logic [2:0] PS_RSVD  = 3'h7;
   localparam logic [3:0] WALKS_DISABLED_CODE    = 4'h0;
   localparam logic [3:0] INVALID_WALK_CODE      = 4'h1;
   localparam logic [3:0] GRANULE_PROTECTION_CODE = 4'h2;
   localparam logic [3:0] EXTERNAL_ABORT_CODE    = 4'h3;

   // ===============================================================
   // Reset values
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [3:0]        code;
      logic              level;
      logic              fault;
   } dptc_synd_s;

endpackage

// ==== dptc_fault_if.sv ====
interface dptc_fault_if;
   logic                      valid;
   logic [dptc_pkg::ADDR_W-1:0] addr;
   logic [3:0]                code;
   logic                      level;
   logic                      no_access;
   logic                      clear;
   logic                      fault;
   logic                      load;
   modport top (output valid, output addr, output code, output level,
                output no_access, output clear, input fault, input load);
   modport synd (input valid, input addr, input code, input level,
                 input no_access, input clear, output fault, output load);
endinterface

// ==== dptc_syndrome.sv ====
module dptc_syndrome #(
   parameter int OA_BITS = 48
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   // Fault report and clear
   dptc_fault_if.synd            flt,
   // Stored syndrome
   output dptc_pkg::dptc_synd_s  synd_out
);

   typedef struct packed {
      dptc_pkg::dptc_synd_s synd;
      logic                 load;
   } dptc_sst_s;

   dptc_sst_s st_r;
   dptc_sst_s st_nxt;
   logic [dptc_pkg::ADDR_W-1:0] oa_mask;

   // ===============================================================
   // Mask for bits above the output address size.
   always_comb begin
      oa_mask = '0;
      for (int i = 0; i < dptc_pkg::ADDR_W; i++) begin
         if (i + dptc_pkg::ADDR_LSB < OA_BITS) begin
            oa_mask[i] = 1'b1;
         end
      end
   end

   // ===============================================================
   // The first fault after a clear is kept; later ones only leave the flag set.
   always_comb begin
      st_nxt      = st_r;
      st_nxt.load = 1'b0;
      if (flt.clear) begin
         st_nxt.synd = '0;
      end
      if (flt.valid && !flt.no_access && (!st_r.synd.fault || flt.clear)) begin
         st_nxt.synd.addr  = flt.addr & oa_mask;
         st_nxt.synd.code  = flt.code;
         st_nxt.synd.level = flt.level;
         st_nxt.synd.fault = 1'b1;
         st_nxt.load       = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign synd_out  = st_r.synd;
   assign flt.fault = st_r.synd.fault;
   assign flt.load  = st_r.load;

endmodule

// ==== dptc_top_chk.sv ====
module dptc_chk #(
   parameter int OA_BITS = 48
) (
   // Clock and reset
   input wire logic                        clk_in,
   input wire logic                        reset_in,
   // Register port
   input wire logic [11:0]                 addr_in,
   input wire logic [31:0]                 wdata_in,
   input wire logic                        wr_in,
   input wire logic                        rd_in,
   input wire logic [31:0]                 rdata_out,
   // Fault report
   input wire logic                        fault_valid_in,
   input wire logic [dptc_pkg::ADDR_W-1:0] fault_addr_in,
   input wire logic [3:0]                  fault_code_in,
   input wire logic                        fault_level_in,
   input wire logic                        fault_no_access_in,
   // Configuration outputs
   input wire logic [dptc_pkg::ADDR_W-1:0] table_base_address_out,
   input wire logic                        read_allocate_hint_out,
   input wire logic [3:0]                  level0_span_out,
   input wire logic [1:0]                  table_granule_out,
   input wire logic [2:0]                  protected_region_size_out,
   input wire logic                        config_valid_out,
   input wire logic                        walk_enable_out,
   input wire logic                        control_acknowledge_out,
   input wire logic                        permission_table_error_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   logic lock;
   logic wcfg;
   logic wlo;
   assign lock = walk_enable_out | control_acknowledge_out;
   assign wcfg = wr_in && addr_in == dptc_pkg::CFG_OFS;
   assign wlo  = wr_in && addr_in == dptc_pkg::BASE_LO_OFS;

   // ===============================================================
   // Register access
   AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 32'h0000_0000)
      else $error("read data not zero outside a read answer");
   AST_ACK_LAG: assert property (control_acknowledge_out == $past(walk_enable_out))
      else $error("acknowledge does not follow walk enable");
   AST_CTRL_WR: assert property (wr_in && addr_in == dptc_pkg::CTRL_OFS
      |=> walk_enable_out == $past(wdata_in[0])) else $error("walk enable not written");
   AST_CFG_LOCK: assert property (wcfg && lock
      |=> $stable({level0_span_out, table_granule_out, protected_region_size_out}))
      else $error("config changed while locked");
   AST_BASE_LOCK: assert property (wlo && lock
      |-> ##2 table_base_address_out == $past(table_base_address_out, 2))
      else $error("base changed while locked");
   AST_CFG_WR: assert property (wcfg && !lock |=> level0_span_out == $past(wdata_in[23:20])
      && table_granule_out == $past(wdata_in[15:14])
      && protected_region_size_out == $past(wdata_in[2:0])) else $error("config not written");
   // Bits 19:13 survive even the largest alignment, so they always follow the write.
   AST_BASE_WR: assert property (wlo && !lock ##1 !wlo
      |=> table_base_address_out[19:13] == $past(wdata_in[31:25], 2))
      else $error("base address not written");
   AST_OA_MASK: assert property (table_base_address_out[dptc_pkg::ADDR_W-1:OA_BITS-12] == '0)
      else $error("base bits above output size not zero");
   AST_CFG_OK: assert property (config_valid_out |-> $past(protected_region_size_out) != 3'h7
      && $past(table_granule_out) != 2'h3 && $past(level0_span_out) inside {4'h0, 4'h4, 4'h6, 4'h9})
      else $error("config marked valid with a reserved code");
   AST_ERR_CAUSE: assert property ($rose(permission_table_error_out)
      |-> $past(fault_valid_in, 2) && !$past(fault_no_access_in, 2))
      else $error("error raised without a lookup fault");
endmodule

bind dptc_top dptc_chk #(.OA_BITS(OA_BITS)) dptc_chk_i (.clk_in, .reset_in, .addr_in, .wdata_in,
   .wr_in, .rd_in, .rdata_out, .fault_valid_in, .fault_addr_in, .fault_code_in, .fault_level_in,
   .fault_no_access_in, .table_base_address_out, .read_allocate_hint_out, .level0_span_out,
   .table_granule_out, .protected_region_size_out, .config_valid_out, .walk_enable_out,
   .control_acknowledge_out, .permission_table_error_out);

// ==== device_permission_table_cfg_tb.sv ====
module device_permission_table_cfg_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in, reset_in, wr_in, rd_in, fault_valid_in, fault_level_in, fault_no_access_in;
   logic read_allocate_hint_out, config_valid_out, walk_enable_out, control_acknowledge_out;
   logic permission_table_error_out;
   logic [11:0] addr_in;
   logic [31:0] wdata_in, rdata_out;
   logic [43:0] fault_addr_in, table_base_address_out;
   logic [3:0]  fault_code_in, level0_span_out;
   logic [1:0]  table_granule_out;
   logic [2:0]  protected_region_size_out;
   int          num_errors = 0;
   int          checks = 0;

   dptc_top dptc_top_i (.clk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
      .fault_valid_in, .fault_addr_in, .fault_code_in, .fault_level_in, .fault_no_access_in,
      .table_base_address_out, .read_allocate_hint_out, .level0_span_out, .table_granule_out,
      .protected_region_size_out, .config_valid_out, .walk_enable_out, .control_acknowledge_out,
      .permission_table_error_out);

   // ===============================================================
   // Shared tasks
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Strobes are set only here, once per edge, so back-to-back calls never race.
   task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_in);
      wr_in <= w;
      rd_in <= r;
      addr_in <= a;
      wdata_in <= d;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, 1'b0, a, d);
      bus(1'b0, 1'b0, a, d);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      bus(1'b0, 1'b1, a, 32'h0000_0000);
      bus(1'b0, 1'b0, a, 32'h0000_0000);
      #1 d = rdata_out;
   endtask
   task automatic flt(input logic na, input logic [43:0] a, input logic [3:0] c, input logic l);
      @(posedge clk_in);
      fault_valid_in <= 1'b1;
      fault_no_access_in <= na;
      fault_addr_in <= a;
      fault_code_in <= c;
      fault_level_in <= l;
      @(posedge clk_in);
      fault_valid_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1;
   endtask

   // ===============================================================
   // Scenarios
   task automatic t_reset;
      logic [11:0] regs [8] = '{12'h200, 12'h204, 12'h208, 12'h210, 12'h214, 12'h220,
                                12'h224, 12'h300};
      logic [31:0] d;
      foreach (regs[i]) begin
         rd(regs[i], d);
         chk(d, 64'h0);
      end
      chk(permission_table_error_out, 1'b0);
   endtask
   task automatic t_cfg;
      logic [31:0] cw [9] = '{32'h0000_0000, 32'h0040_4001, 32'h0060_8002, 32'h0090_0005,
                              32'h0090_0000, 32'h0010_0000, 32'h0000_C000, 32'h0000_0007,
                              32'h0000_0006};
      logic [8:0]  cv = 9'b0_0000_1111;
      logic [31:0] d;
      foreach (cw[i]) begin
         wr(dptc_pkg::CFG_OFS, cw[i]);
         rd(dptc_pkg::CFG_OFS, d);
         chk(d, cw[i]);
         chk({level0_span_out, table_granule_out, protected_region_size_out},
             {cw[i][23:20], cw[i][15:14], cw[i][2:0]});
         chk(config_valid_out, cv[i]);
      end
      wr(dptc_pkg::CFG_OFS, 32'h0000_0000);
   endtask
   task automatic t_base;
      logic [31:0] d;
      wr(dptc_pkg::BASE_LO_OFS, 32'hABCD_E000);
      wr(dptc_pkg::BASE_HI_OFS, 32'h40FF_1234);
      rd(dptc_pkg::BASE_LO_OFS, d);
      chk(d, 32'hABCD_E000);
      chk(table_base_address_out, 44'h001_234A_BCDE);
      chk(read_allocate_hint_out, 1'b1);
   endtask
   task automatic t_lock;
      logic [31:0] d;
      wr(dptc_pkg::CTRL_OFS, 32'h0000_0001);
      rd(dptc_pkg::CTRL_OFS, d);
      chk(d, 32'h0000_0003);
      wr(dptc_pkg::BASE_LO_OFS, 32'h0000_0000);
      wr(dptc_pkg::CFG_OFS, 32'h0000_0001);
      rd(dptc_pkg::CFG_OFS, d);
      chk(d, 32'h0000_0000);
      // The acknowledge lags enable by a cycle, so a write right behind the clear is refused.
      bus(1'b1, 1'b0, dptc_pkg::CTRL_OFS, 32'h0000_0000);
      bus(1'b1, 1'b0, dptc_pkg::BASE_LO_OFS, 32'h1111_1000);
      bus(1'b0, 1'b0, dptc_pkg::BASE_LO_OFS, 32'h0000_0000);
      rd(dptc_pkg::BASE_LO_OFS, d);
      chk(d, 32'hABCD_E000);
      wr(dptc_pkg::BASE_LO_OFS, 32'h1111_1000);
      rd(dptc_pkg::BASE_LO_OFS, d);
      chk(d, 32'h1111_1000);
   endtask
   task automatic t_fault;
      logic [43:0] a = 44'hFF1_2345_6789;
      logic [31:0] d;
      logic [31:0] g;
      wr(dptc_pkg::SYND_LO_OFS, 32'h0000_0001);
      rd(dptc_pkg::SYND_LO_OFS, d);
      chk({d, 31'h0, permission_table_error_out}, 64'h0);
      flt(1'b1, a, 4'h2, 1'b1);
      rd(dptc_pkg::SYND_LO_OFS, d);
      chk({d, 31'h0, permission_table_error_out}, 64'h0);
      for (int c = 0; c < 4; c++) begin
         flt(1'b0, a, c[3:0], c[0]);
         chk(permission_table_error_out, 1'b1);
         flt(1'b0, ~a, 4'h1, ~c[0]);
         rd(dptc_pkg::SYND_LO_OFS, d);
         chk(d, {20'h56789, 4'h0, c[3:0], 2'b00, c[0], 1'b1});
         rd(dptc_pkg::SYND_HI_OFS, d);
         chk(d, 32'h0000_1234);
         wr(dptc_pkg::SYND_LO_OFS, 32'hFFFF_FFF1);
         rd(dptc_pkg::SYND_LO_OFS, d);
         chk(d, {20'h56789, 4'h0, c[3:0], 2'b00, c[0], 1'b1});
         wr(dptc_pkg::SYND_LO_OFS, 32'h0000_0000);
         rd(dptc_pkg::SYND_LO_OFS, d);
         chk(d, 32'h0000_0000);
         rd(dptc_pkg::SYND_HI_OFS, d);
         chk(d, 32'h0000_0000);
         rd(dptc_pkg::GERR_OFS, g);
         wr(dptc_pkg::GERR_OFS, {30'h0, g[0], 1'b0});
         rd(dptc_pkg::GERR_OFS, g);
         chk(permission_table_error_out, 1'b0);
      end
   endtask

   // ===============================================================
   // Run control
   task automatic results;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // The tests need about 210 cycles; some twenty-four times that means a hang.
   initial begin
      repeat (5000) @(posedge clk_in);
      num_errors++;
      $display("FAIL %0t: watchdog expired", $time);
      results();
   end
   initial begin
      {wr_in, rd_in, fault_valid_in, fault_level_in, fault_no_access_in} = 5'b0_0000;
      addr_in = 12'h000;
      wdata_in = 32'h0000_0000;
      fault_addr_in = 44'h000_0000_0000;
      fault_code_in = 4'h0;
      reset_in = 1'b1;
      repeat (8) @(posedge clk_in);
      reset_in <= 1'b0;
      t_reset();
      $display("reset test done");
      t_cfg();
      $display("config test done");
      t_base();
      $display("base test done");
      t_lock();
      $display("lock test done");
      t_fault();
      $display("fault test done");
      results();
   end
endmodule
